// >>> mls_pkg.sv
// Constants, register map and types of the serial link supervisor
package mls_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_UNIT_MS = 100;

    // Register byte offsets
    localparam logic [7:0] OFS_STATION = 8'h00;
    localparam logic [7:0] OFS_REPLY_DELAY = 8'h04;
    localparam logic [7:0] OFS_TIMEOUT = 8'h08;
    localparam logic [7:0] OFS_RX_COUNT = 8'h0c;
    localparam logic [7:0] OFS_TX_COUNT = 8'h10;
    localparam logic [7:0] OFS_CRC_COUNT = 8'h14;
    localparam logic [7:0] OFS_ROLE = 8'h18;
    localparam logic [7:0] OFS_TARGET = 8'h1c;
    localparam logic [7:0] OFS_QUANTITY = 8'h20;
    localparam logic [7:0] OFS_INTERVAL = 8'h24;
    localparam logic [7:0] OFS_SCALE = 8'h28;
    localparam logic [7:0] OFS_SPEED_UNIT = 8'h2c;
    localparam logic [7:0] OFS_WRITE_REPLY = 8'h30;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h34;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h38;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h3c;

    // Reset values
    localparam logic [15:0] RST_STATION = 16'h0001;
    localparam logic [15:0] RST_REPLY_DELAY = 16'h0002;
    localparam logic [15:0] RST_TIMEOUT = 16'h0000;
    localparam logic [15:0] RST_TARGET = 16'h0001;
    localparam logic [15:0] RST_QUANTITY = 16'h0000;
    localparam logic [15:0] RST_INTERVAL = 16'h0064;
    localparam logic [15:0] RST_SCALE = 16'h03e8;
    localparam logic [15:0] RST_SPEED_UNIT = 16'h0000;

    // Legal ranges
    localparam logic [15:0] STATION_MIN = 16'h0001;
    localparam logic [15:0] STATION_MAX = 16'h00f7;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;
    localparam logic [15:0] DELAY_MIN = 16'h0001;
    localparam logic [15:0] DELAY_MAX = 16'h0014;
    localparam logic [15:0] TIMEOUT_MAX = 16'h0258;
    localparam logic [15:0] TARGET_MIN = 16'h0001;
    localparam logic [15:0] TARGET_MAX = 16'h0009;
    localparam logic [15:0] QUANTITY_MAX = 16'h0006;
    localparam logic [15:0] INTERVAL_MIN = 16'h000a;
    localparam logic [15:0] INTERVAL_MAX = 16'h2710;
    localparam logic signed [15:0] SCALE_MIN = 16'shd8f0;
    localparam logic signed [15:0] SCALE_MAX = 16'sh2710;
    localparam logic [15:0] SPEED_UNIT_MAX = 16'h0002;
    localparam logic [15:0] FLAG_MAX = 16'h0001;

    // Slave registers reached by broadcast and scaled on arrival
    localparam logic [15:0] TARGET_REG_BASE = 16'h7000;
    localparam logic [15:0] SCALE_REG_A = 16'h7001;
    localparam logic [15:0] SCALE_REG_B = 16'h7002;
    localparam logic signed [31:0] SCALE_ONE = 32'sd1000;

    // Event bits of the interrupt registers
    localparam int EV_TIMEOUT = 0;
    localparam int EV_CRC = 1;
    localparam int EV_BCAST = 2;
    localparam int EV_REPLY = 3;
    localparam int EV_W = 4;

    typedef enum logic [1:0] {
        RP_IDLE = 2'b00,
        RP_WAIT = 2'b01
    } mls_reply_t;
endpackage

// >>> mls_scale.sv
// Inbound value scaler with saturation
`timescale 1ns/1ps
module mls_scale
    import mls_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic valid_i,
    input wire logic sel_i,
    input wire logic [15:0] data_i,
    input wire logic [15:0] factor_i,
    output logic valid_o,
    output logic sel_o,
    output logic [15:0] data_o
);
    logic valid_r, valid_nxt;
    logic sel_r, sel_nxt;
    logic [15:0] data_r, data_nxt;
    logic signed [31:0] prod;
    logic signed [31:0] quot;

    always_comb begin
        prod = $signed(data_i) * $signed(factor_i);
        quot = prod / SCALE_ONE;
        valid_nxt = valid_i;
        sel_nxt = valid_i ? sel_i : sel_r;
        data_nxt = data_r;
        if (valid_i) begin
            // Saturate to the signed 16-bit range
            if (quot > 32'sd32767) begin
                data_nxt = 16'h7fff;
            end else if (quot < -32'sd32768) begin
                data_nxt = 16'h8000;
            end else begin
                data_nxt = quot[15:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            valid_r <= 1'b0;
            sel_r <= 1'b0;
            data_r <= 16'h0000;
        end else if (ce_i) begin
            valid_r <= valid_nxt;
            sel_r <= sel_nxt;
            data_r <= data_nxt;
        end
    end

    assign valid_o = valid_r;
    assign sel_o = sel_r;
    assign data_o = data_r;
endmodule

// >>> mls_top.sv
// Serial link supervisor: timeout, counters, role, broadcast and reply timing
// Function
// - Timeout settable zero (off) to sixty seconds
// - No master data in time trips fault
// - Reply waits 1 to 20 ms delay
// - Unique station 1 to 247, 0 broadcast
// - Received data counter, 16-bit wrapping
// - Transmitted data counter, 16-bit wrapping
// - CRC failed frames counted, 16-bit wrapping
// - Role zero slave, one broadcasting master
// - Target 1 to 9 selects 0x7001-0x7009
// - Master waits interval between broadcast frames
// - Slave scales values for 0x7001, 0x7002
// - Speed unit code 0, 1, 2
// - Write frames replied unless suppression set
`timescale 1ns/1ps
module mls_top
    import mls_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic frame_done_i,
    input wire logic frame_crc_ok_i,
    input wire logic [7:0] frame_station_i,
    input wire logic frame_is_write_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_data_i,
    output logic reply_start_o,
    output logic bcast_send_o,
    output logic [15:0] bcast_reg_o,
    output logic [2:0] bcast_quantity_o,
    output logic role_master_o,
    output logic [1:0] speed_unit_o,
    output logic scaled_valid_o,
    output logic scaled_sel_o,
    output logic [15:0] scaled_data_o,
    output logic link_timeout_fault_o,
    output logic irq_o
);
    // Bus slave state
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic addr_phase;
    // Configuration
    logic [15:0] station_r, station_nxt;
    logic [15:0] delay_r, delay_nxt;
    logic [15:0] timeout_r, timeout_nxt;
    logic role_r, role_nxt;
    logic [15:0] target_r, target_nxt;
    logic [15:0] quantity_r, quantity_nxt;
    logic [15:0] interval_r, interval_nxt;
    logic [15:0] scale_r, scale_nxt;
    logic [15:0] speed_r, speed_nxt;
    logic wreply_r, wreply_nxt;
    logic [EV_W-1:0] irq_en_r, irq_en_nxt;
    logic [15:0] wdata;
    logic wr_ok;
    // Counters and timers
    logic [15:0] rx_cnt_r, rx_cnt_nxt;
    logic [15:0] tx_cnt_r, tx_cnt_nxt;
    logic [15:0] crc_cnt_r, crc_cnt_nxt;
    logic [13:0] pre_r, pre_nxt;
    logic [15:0] to_cnt_r, to_cnt_nxt;
    logic [15:0] iv_cnt_r, iv_cnt_nxt;
    logic [15:0] to_limit;
    logic tick, good_frame, bad_frame, for_us;
    logic ev_timeout, ev_bcast;
    logic bcast_r, bcast_nxt;
    logic [15:0] bcast_reg_r, bcast_reg_nxt;
    logic [2:0] bcast_qty_r, bcast_qty_nxt;
    // Reply timing
    mls_reply_t rp_state_r, rp_state_nxt;
    logic [13:0] rp_sub_r, rp_sub_nxt;
    logic [4:0] rp_ms_r, rp_ms_nxt;
    logic reply_r, reply_nxt;
    logic reply_due;
    // Interrupts and fault
    logic [EV_W-1:0] irq_st_r, irq_st_nxt;
    logic [EV_W-1:0] events, irq_clr;
    logic fault_r, fault_nxt;
    logic irq_r, irq_nxt;
    // AHB-Lite slave with no wait states
    always_comb begin
        addr_phase = hsel_i && hready_i && htrans_i[1];
        wr_pend_nxt = addr_phase && hwrite_i;
        wr_addr_nxt = addr_phase ? haddr_i[7:0] : wr_addr_r;
        hrdata_nxt = 32'h00000000;
        // Read data follows the next values so a write just before is seen
        if (addr_phase && !hwrite_i) begin
            case (haddr_i[7:0])
                OFS_STATION: hrdata_nxt[15:0] = station_nxt;
                OFS_REPLY_DELAY: hrdata_nxt[15:0] = delay_nxt;
                OFS_TIMEOUT: hrdata_nxt[15:0] = timeout_nxt;
                OFS_RX_COUNT: hrdata_nxt[15:0] = rx_cnt_nxt;
                OFS_TX_COUNT: hrdata_nxt[15:0] = tx_cnt_nxt;
                OFS_CRC_COUNT: hrdata_nxt[15:0] = crc_cnt_nxt;
                OFS_ROLE: hrdata_nxt[0] = role_nxt;
                OFS_TARGET: hrdata_nxt[15:0] = target_nxt;
                OFS_QUANTITY: hrdata_nxt[15:0] = quantity_nxt;
                OFS_INTERVAL: hrdata_nxt[15:0] = interval_nxt;
                OFS_SCALE: hrdata_nxt[15:0] = scale_nxt;
                OFS_SPEED_UNIT: hrdata_nxt[15:0] = speed_nxt;
                OFS_WRITE_REPLY: hrdata_nxt[0] = wreply_nxt;
                OFS_IRQ_STATUS: hrdata_nxt[EV_W-1:0] = irq_st_nxt;
                OFS_IRQ_ENABLE: hrdata_nxt[EV_W-1:0] = irq_en_nxt;
                default: hrdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Configuration writes; an out-of-range value leaves the register unchanged
    always_comb begin
        wdata = hwdata_i[15:0];
        wr_ok = wr_pend_r && (hwdata_i[31:16] == 16'h0000);
        station_nxt = station_r;
        delay_nxt = delay_r;
        timeout_nxt = timeout_r;
        role_nxt = role_r;
        target_nxt = target_r;
        quantity_nxt = quantity_r;
        interval_nxt = interval_r;
        scale_nxt = scale_r;
        speed_nxt = speed_r;
        wreply_nxt = wreply_r;
        irq_en_nxt = irq_en_r;
        irq_clr = '0;
        if (wr_pend_r) begin
            case (wr_addr_r)
                OFS_STATION: if (wr_ok && wdata >= STATION_MIN && wdata <= STATION_MAX) station_nxt = wdata;
                OFS_REPLY_DELAY: if (wr_ok && wdata >= DELAY_MIN && wdata <= DELAY_MAX) delay_nxt = wdata;
                OFS_TIMEOUT: if (wr_ok && wdata <= TIMEOUT_MAX) timeout_nxt = wdata;
                OFS_ROLE: if (wr_ok && wdata <= FLAG_MAX) role_nxt = wdata[0];
                OFS_TARGET: if (wr_ok && wdata >= TARGET_MIN && wdata <= TARGET_MAX) target_nxt = wdata;
                OFS_QUANTITY: if (wr_ok && wdata <= QUANTITY_MAX) quantity_nxt = wdata;
                OFS_INTERVAL: if (wr_ok && wdata >= INTERVAL_MIN && wdata <= INTERVAL_MAX) interval_nxt = wdata;
                OFS_SCALE: if ($signed(hwdata_i) >= 32'(SCALE_MIN) && $signed(hwdata_i) <= 32'(SCALE_MAX)) scale_nxt = wdata;
                OFS_SPEED_UNIT: if (wr_ok && wdata <= SPEED_UNIT_MAX) speed_nxt = wdata;
                OFS_WRITE_REPLY: if (wr_ok && wdata <= FLAG_MAX) wreply_nxt = wdata[0];
                OFS_IRQ_ENABLE: irq_en_nxt = hwdata_i[EV_W-1:0];
                OFS_IRQ_CLEAR: irq_clr = hwdata_i[EV_W-1:0];
                default: irq_clr = '0;
            endcase
        end
    end

    // Frame accounting, link timeout and broadcast pacing
    always_comb begin
        tick = (pre_r == 14'(MS_CYCLES - 1));
        pre_nxt = tick ? 14'h0000 : pre_r + 14'h0001;
        for_us = (frame_station_i == station_r[7:0]) || (frame_station_i == BROADCAST_ADDR);
        good_frame = frame_done_i && frame_crc_ok_i;
        bad_frame = frame_done_i && !frame_crc_ok_i;
        rx_cnt_nxt = rx_cnt_r + ((good_frame && for_us) ? 16'h0001 : 16'h0000);
        tx_cnt_nxt = tx_cnt_r + ((reply_r || bcast_r) ? 16'h0001 : 16'h0000);
        crc_cnt_nxt = crc_cnt_r + (bad_frame ? 16'h0001 : 16'h0000);
        to_limit = 16'(timeout_r * TIMEOUT_UNIT_MS);
        to_cnt_nxt = to_cnt_r;
        ev_timeout = 1'b0;
        // Timeout runs only in slave role and only when set above zero
        if (role_r || timeout_r == 16'h0000 || good_frame) begin
            to_cnt_nxt = 16'h0000;
        end else if (tick && to_cnt_r != to_limit) begin
            to_cnt_nxt = to_cnt_r + 16'h0001;
            ev_timeout = (to_cnt_nxt == to_limit);
        end
        iv_cnt_nxt = iv_cnt_r;
        ev_bcast = 1'b0;
        if (!role_r) begin
            iv_cnt_nxt = 16'h0000;
        end else if (tick) begin
            if (iv_cnt_r >= interval_r - 16'h0001) begin
                iv_cnt_nxt = 16'h0000;
                ev_bcast = 1'b1;
            end else begin
                iv_cnt_nxt = iv_cnt_r + 16'h0001;
            end
        end
        bcast_nxt = ev_bcast;
        bcast_reg_nxt = ev_bcast ? TARGET_REG_BASE + target_r : bcast_reg_r;
        bcast_qty_nxt = ev_bcast ? quantity_r[2:0] : bcast_qty_r;
    end

    // Reply delay; bad frames and suppressed writes never start a reply
    always_comb begin
        rp_state_nxt = rp_state_r;
        rp_sub_nxt = rp_sub_r;
        rp_ms_nxt = rp_ms_r;
        reply_due = 1'b0;
        case (rp_state_r)
            RP_IDLE: begin
                rp_sub_nxt = 14'h0000;
                rp_ms_nxt = 5'h00;
            end
            RP_WAIT: begin
                if (rp_sub_r == 14'(MS_CYCLES - 1)) begin
                    rp_sub_nxt = 14'h0000;
                    rp_ms_nxt = rp_ms_r + 5'h01;
                    if (rp_ms_nxt == delay_r[4:0]) begin
                        reply_due = 1'b1;
                        rp_state_nxt = RP_IDLE;
                    end
                end else begin
                    rp_sub_nxt = rp_sub_r + 14'h0001;
                end
            end
            default: rp_state_nxt = RP_IDLE;
        endcase
        // A fresh request restarts the delay; broadcasts are never answered
        if (good_frame && !role_r && frame_station_i == station_r[7:0]
            && !(frame_is_write_i && wreply_r)) begin
            rp_state_nxt = RP_WAIT;
            rp_sub_nxt = 14'h0000;
            rp_ms_nxt = 5'h00;
            reply_due = 1'b0;
        end
        reply_nxt = reply_due;
    end

    // Sticky status, set wins over clear; fault clears with its status bit
    always_comb begin
        events = '0;
        events[EV_TIMEOUT] = ev_timeout;
        events[EV_CRC] = bad_frame;
        events[EV_BCAST] = ev_bcast;
        events[EV_REPLY] = reply_due;
        irq_st_nxt = (irq_st_r & ~irq_clr) | events;
        fault_nxt = (fault_r && !irq_clr[EV_TIMEOUT]) || ev_timeout;
        irq_nxt = |(irq_st_nxt & irq_en_nxt);
    end
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
            station_r <= RST_STATION;
            delay_r <= RST_REPLY_DELAY;
            timeout_r <= RST_TIMEOUT;
            role_r <= 1'b0;
            target_r <= RST_TARGET;
            quantity_r <= RST_QUANTITY;
            interval_r <= RST_INTERVAL;
            scale_r <= RST_SCALE;
            speed_r <= RST_SPEED_UNIT;
            wreply_r <= 1'b0;
            irq_en_r <= '0;
            rx_cnt_r <= 16'h0000;
            tx_cnt_r <= 16'h0000;
            crc_cnt_r <= 16'h0000;
            pre_r <= 14'h0000;
            to_cnt_r <= 16'h0000;
            iv_cnt_r <= 16'h0000;
            bcast_r <= 1'b0;
            bcast_reg_r <= TARGET_REG_BASE;
            bcast_qty_r <= 3'h0;
            rp_state_r <= RP_IDLE;
            rp_sub_r <= 14'h0000;
            rp_ms_r <= 5'h00;
            reply_r <= 1'b0;
            irq_st_r <= '0;
            fault_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce_i) begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r <= hrdata_nxt;
            station_r <= station_nxt;
            delay_r <= delay_nxt;
            timeout_r <= timeout_nxt;
            role_r <= role_nxt;
            target_r <= target_nxt;
            quantity_r <= quantity_nxt;
            interval_r <= interval_nxt;
            scale_r <= scale_nxt;
            speed_r <= speed_nxt;
            wreply_r <= wreply_nxt;
            irq_en_r <= irq_en_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            crc_cnt_r <= crc_cnt_nxt;
            pre_r <= pre_nxt;
            to_cnt_r <= to_cnt_nxt;
            iv_cnt_r <= iv_cnt_nxt;
            bcast_r <= bcast_nxt;
            bcast_reg_r <= bcast_reg_nxt;
            bcast_qty_r <= bcast_qty_nxt;
            rp_state_r <= rp_state_nxt;
            rp_sub_r <= rp_sub_nxt;
            rp_ms_r <= rp_ms_nxt;
            reply_r <= reply_nxt;
            irq_st_r <= irq_st_nxt;
            fault_r <= fault_nxt;
            irq_r <= irq_nxt;
        end
    end
    // Values for 0x7001 and 0x7002 are scaled in slave role only
    mls_scale u_scale (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .valid_i(reg_wr_i && !role_r && (reg_addr_i == SCALE_REG_A || reg_addr_i == SCALE_REG_B)),
        .sel_i(reg_addr_i == SCALE_REG_B),
        .data_i(reg_data_i),
        .factor_i(scale_r),
        .valid_o(scaled_valid_o),
        .sel_o(scaled_sel_o),
        .data_o(scaled_data_o)
    );
    assign hrdata_o = hrdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign reply_start_o = reply_r;
    assign bcast_send_o = bcast_r;
    assign bcast_reg_o = bcast_reg_r;
    assign bcast_quantity_o = bcast_qty_r;
    assign role_master_o = role_r;
    assign speed_unit_o = speed_r[1:0];
    assign link_timeout_fault_o = fault_r;
    assign irq_o = irq_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_bad_frame;
        ce_i && frame_done_i && !frame_crc_ok_i;
    endsequence
    sequence s_good_own;
        ce_i && frame_done_i && frame_crc_ok_i && for_us;
    endsequence
    a_crc_count_step: assert property (s_bad_frame |=> crc_cnt_r == $past(crc_cnt_r) + 16'h0001)
        else $error("crc error counter did not step");
    a_rx_count_step: assert property (s_good_own |=> rx_cnt_r == $past(rx_cnt_r) + 16'h0001)
        else $error("receive counter did not step");
    a_rx_bad_hold: assert property (s_bad_frame |=> rx_cnt_r == $past(rx_cnt_r))
        else $error("receive counter moved on a bad frame");
    a_tx_count_step: assert property (ce_i && reply_r && !bcast_r |=> tx_cnt_r == $past(tx_cnt_r) + 16'h0001)
        else $error("transmit counter did not step");
    a_bad_no_wait: assert property ((s_bad_frame and (rp_state_r == RP_IDLE)) |=> rp_state_r == RP_IDLE)
        else $error("bad frame started a reply");
    a_suppressed_write: assert property (ce_i && good_frame && frame_is_write_i && wreply_r && rp_state_r == RP_IDLE
        |=> rp_state_r == RP_IDLE)
        else $error("suppressed write was answered");
    a_reply_not_early: assert property (ce_i && rp_state_r == RP_IDLE ##1 rp_state_r == RP_WAIT |-> !reply_r [*3])
        else $error("reply came without delay");
    a_bcast_target: assert property (bcast_r |-> bcast_reg_r == TARGET_REG_BASE + $past(target_r))
        else $error("broadcast target register wrong");
    a_bcast_master: assert property (bcast_r |-> $past(role_r))
        else $error("broadcast sent in slave role");
    a_timeout_trip: assert property (ce_i && ev_timeout |=> link_timeout_fault_o && irq_st_r[EV_TIMEOUT])
        else $error("timeout did not trip the fault");
    a_timeout_off: assert property (timeout_r == 16'h0000 |-> !ev_timeout)
        else $error("disabled timeout tripped");
    a_irq_level: assert property (ce_i |=> irq_o == |(irq_st_r & irq_en_r))
        else $error("interrupt level disagrees with status");
endmodule

// >>> mls_frame_model.sv
// Frame engine model feeding the supervisor with ended frames and register writes
`timescale 1ns/1ps
module mls_frame_model (
    input wire logic clk_i,
    output logic done_o,
    output logic crc_ok_o,
    output logic [7:0] station_o,
    output logic is_write_o,
    output logic reg_wr_o,
    output logic [15:0] reg_addr_o,
    output logic [15:0] reg_data_o
);
    initial begin
        {done_o, crc_ok_o, is_write_o, reg_wr_o} = 4'h0;
        station_o = 8'h5a;
        {reg_addr_o, reg_data_o} = 32'ha5a5a5a5;
    end
    task frame(input logic ok, input logic [7:0] st, input logic wr);
        @(posedge clk_i);
        done_o <= 1'b1;
        crc_ok_o <= ok;
        station_o <= st;
        is_write_o <= wr;
        @(posedge clk_i);
        done_o <= 1'b0;
        station_o <= ~st;
    endtask
    // Drives the register write strobe for one clock with address and data, with no frame or CRC check
    task regw(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_o <= 1'b1;
        {reg_addr_o, reg_data_o} <= {a, d};
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        {reg_addr_o, reg_data_o} <= ~{a, d};
    endtask
endmodule

// >>> mls_top_tb_top.sv
// Self-checking bench of the serial link supervisor
`timescale 1ns/1ps
module mls_top_tb_top;
    import mls_pkg::*;
    localparam int MSC = 10;
    logic clk_i, reset_n_i, hsel, hwrite, hreadyout_o, hresp_o, reply_start_o, bcast_send_o, role_master_o;
    logic scaled_valid_o, scaled_sel_o, link_timeout_fault_o, irq_o, fd, fok, fw, rw, hit;
    logic [1:0] htrans, speed_unit_o;
    logic [2:0] bcast_quantity_o;
    logic [7:0] fst;
    logic [15:0] bcast_reg_o, scaled_data_o, ra, rd16;
    logic [31:0] haddr, hwdata, hrdata_o, q, rnd;
    logic ce = 1'b1;
    int miscompares = 0, tests_run = 0, rx_m = 0, crc_m = 0, tx_m = 0, n, p;
    logic [7:0] ro[8] = '{OFS_STATION, OFS_REPLY_DELAY, OFS_TIMEOUT, OFS_ROLE, OFS_TARGET, OFS_INTERVAL,
        OFS_SCALE, OFS_WRITE_REPLY};
    logic [15:0] rv[8] = '{16'h1, 16'h2, 16'h0, 16'h0, 16'h1, 16'h64, 16'h3e8, 16'h0};
    mls_frame_model fe (.clk_i(clk_i), .done_o(fd), .crc_ok_o(fok), .station_o(fst), .is_write_o(fw),
        .reg_wr_o(rw), .reg_addr_o(ra), .reg_data_o(rd16));
    mls_top #(.MS_CYCLES(MSC)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .frame_done_i(fd), .frame_crc_ok_i(fok), .frame_station_i(fst), .frame_is_write_i(fw),
        .reg_wr_i(rw), .reg_addr_i(ra), .reg_data_i(rd16), .reply_start_o(reply_start_o),
        .bcast_send_o(bcast_send_o), .bcast_reg_o(bcast_reg_o), .bcast_quantity_o(bcast_quantity_o),
        .role_master_o(role_master_o), .speed_unit_o(speed_unit_o), .scaled_valid_o(scaled_valid_o),
        .scaled_sel_o(scaled_sel_o), .scaled_data_o(scaled_data_o),
        .link_timeout_fault_o(link_timeout_fault_o), .irq_o(irq_o));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask
    task quiet(input int c);
        hit = 0;
        repeat (c) @(negedge clk_i) if (reply_start_o !== 1'b0) hit = 1;
        chk(hit, 0);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_i) if (reply_start_o === 1'b1 || bcast_send_o === 1'b1) tx_m <= tx_m + 1;
    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        {reset_n_i, hsel, hwrite, htrans, haddr, hwdata, rnd} = {5'h0, 64'h0, 32'hb5df};
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (ro[i]) begin
            ahb(0, ro[i], 0);
            chk(q, rv[i]);
        end
        ahb(0, 8'h40, 0);
        chk(q, 0);
        chk({hreadyout_o, hresp_o}, 2'b10);
        ahb(1, OFS_STATION, 248);
        ahb(0, OFS_STATION, 0);
        chk(q, 1);
        ahb(1, OFS_REPLY_DELAY, 1);
        fe.frame(1, 8'h01, 0);
        rx_m++;
        n = 0;
        do begin @(negedge clk_i); n++; end while (reply_start_o !== 1'b1 && n < 40);
        chk(n, MSC + 1);
        ahb(1, OFS_WRITE_REPLY, 1);
        for (int i = 0; i < 4; i++) begin
            fe.frame(i != 0, (i == 3) ? 8'h02 : {7'h0, i != 2}, i == 1);
            rx_m += (i == 1 || i == 2);
            crc_m += (i == 0);
            quiet(30);
        end
        // A frame that ends while the clock enable is low is not counted
        @(posedge clk_i) ce <= 1'b0;
        fe.frame(0, 8'h01, 0);
        ce <= 1'b1;
        ahb(0, OFS_RX_COUNT, 0);
        chk(q, rx_m);
        ahb(0, OFS_CRC_COUNT, 0);
        chk(q, crc_m);
        ahb(1, OFS_IRQ_ENABLE, 2);
        repeat (3) @(negedge clk_i);
        chk(irq_o, 1);
        ahb(1, OFS_IRQ_ENABLE, 0);
        repeat (3) @(negedge clk_i);
        chk(irq_o, 0);
        ahb(1, OFS_IRQ_CLEAR, 2);
        ahb(0, OFS_IRQ_STATUS, 0);
        chk(q[1], 0);
        for (int i = 2; i >= 0; i--) begin
            ahb(1, OFS_SPEED_UNIT, i);
            @(negedge clk_i);
            chk(speed_unit_o, i);
        end
        ahb(1, OFS_SCALE, -3000);
        ahb(1, OFS_SCALE, 32'hffff_f448);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            fe.regw(SCALE_REG_A + i[0], rnd[15:0]);
            @(negedge clk_i);
            p = $signed(rnd[15:0]) * -3000 / 1000;
            p = (p > 32767) ? 32767 : (p < -32768) ? -32768 : p;
            chk({scaled_valid_o, scaled_sel_o, scaled_data_o}, {1'b1, i[0], p[15:0]});
        end
        ahb(1, OFS_TIMEOUT, 1);
        fe.frame(1, 8'h00, 0);
        repeat (940) @(negedge clk_i);
        chk(link_timeout_fault_o, 0);
        repeat (80) @(negedge clk_i);
        chk(link_timeout_fault_o, 1);
        ahb(1, OFS_TIMEOUT, 0);
        ahb(1, OFS_IRQ_CLEAR, 1);
        @(negedge clk_i);
        chk(link_timeout_fault_o, 0);
        ahb(1, OFS_TARGET, 9);
        ahb(1, OFS_INTERVAL, 10);
        ahb(1, OFS_QUANTITY, 5);
        ahb(1, OFS_ROLE, 1);
        n = 0;
        do begin @(negedge clk_i); n++; end while (bcast_send_o !== 1'b1 && n < 200);
        chk({role_master_o, bcast_quantity_o, bcast_reg_o}, {1'b1, 3'h5, 16'h7009});
        n = 0;
        do begin @(negedge clk_i); n++; end while (bcast_send_o !== 1'b1 && n < 200);
        chk(n, 10 * MSC);
        ahb(1, OFS_ROLE, 0);
        ahb(0, OFS_TX_COUNT, 0);
        chk(q, tx_m);
        tally_and_finish;
    end
endmodule
